//--- verilog/dpdio_cfg.svh
// Constants for the dual digital I/O port block: addresses, widths,
// reset values and alternate-function bit positions.
// Assumes it is included by bare name from every file that needs it.
`ifndef DPDIO_CFG_SVH
`define DPDIO_CFG_SVH

// Register bus geometry
`define DPDIO_ADDR_W    6
`define DPDIO_DATA_W    8
`define DPDIO_BIDX_W    3

// Port widths
`define DPDIO_WIDE_W    8
`define DPDIO_NARROW_W  7

// I/O space addresses
`define DPDIO_ADDR_NPIN 6'h10
`define DPDIO_ADDR_NDIR 6'h11
`define DPDIO_ADDR_NLAT 6'h12
`define DPDIO_ADDR_WPIN 6'h16
`define DPDIO_ADDR_WDIR 6'h17
`define DPDIO_ADDR_WLAT 6'h18

// Reset and idle values
`define DPDIO_LAT_RST   8'h00
`define DPDIO_DIR_RST   8'h00
`define DPDIO_RD_IDLE   8'h00
`define DPDIO_SYNC_RST  1'b0

// Alternate-function bit positions
`define DPDIO_BIT_SCK   7
`define DPDIO_BIT_SDO   6
`define DPDIO_BIT_SDI   5
`define DPDIO_BIT_CNEG  1
`define DPDIO_BIT_CPOS  0
`define DPDIO_BIT_TCLK  4
`define DPDIO_BIT_IRQ0  2

`endif

//--- verilog/dpdio_pkg.sv
// Types shared by the dual digital I/O port block.
// Assumes nothing of its surroundings; holds no constants of its own.
`default_nettype none

package dpdio_pkg;

  // One-hot register select produced by the address decoder
  typedef enum logic [6:0] {
    SEL_NONE = 7'b0000001,
    SEL_NPIN = 7'b0000010,
    SEL_NDIR = 7'b0000100,
    SEL_NLAT = 7'b0001000,
    SEL_WPIN = 7'b0010000,
    SEL_WDIR = 7'b0100000,
    SEL_WLAT = 7'b1000000
  } dpdio_sel_t;

endpackage

`default_nettype wire

//--- verilog/dpdio_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the inputs come straight from pads, outside the clk domain.
`default_nettype none
`include "dpdio_cfg.svh"

module dpdio_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] stage1_reg;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second; nothing else may look at it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1_reg <= {W{`DPDIO_SYNC_RST}};
      dout       <= {W{`DPDIO_SYNC_RST}};
    end else begin
      stage1_reg <= din;
      dout       <= stage1_reg;
    end
  end

endmodule

`default_nettype wire

//--- verilog/dpdio_top.sv
// Dual general-purpose digital I/O port: an eight-pin wide port and a
// seven-pin narrow port, each with direction, output latch, pull-up
// control and a read-only pin-level address on the core's I/O bus.
// Assumes a single-cycle I/O bus from the core on clk, pads that turn
// out/oe/pull-up into a real wire, and asynchronous pin levels.
//
// Operation
// R01: A wide pin drives its latch bit push-pull when its direction bit is one, else it is an input.
// R02: A wide pin's pull-up is on only while it is an input with latch bit one.
// R03: Every wide pin floats as soon as reset is active, clock or no clock.
// R04: Reading the wide latch returns the latch; the wide pin address returns pin levels.
// R05: All eight wide pins behave alike, one direction bit and one latch bit each. The code overrides bits 7 to 5 while progModeEn is set.
// R06: Wide bit 7 is serial clock in, bit 6 serial data out, bit 5 serial data in.
// R07: Software keeps wide bits 1 and 0 as inputs without pull-up when the comparator uses them.
// R08: Every pin input is synchronised before it is read or used inside.
// R09: The narrow port has a latch, a direction register and a read-only pin address.
// R10: The narrow port has pins 6 to 0; bit 7 reads zero everywhere; latch and direction reset to zero.
// R11: A narrow pin drives its latch bit push-pull when its direction bit is one, else it is an input.
// R12: A narrow pin's pull-up is on only while it is an input with latch bit one.
// R13: Every narrow pin floats as soon as reset is active, clock or no clock.
// R14: Reading the narrow latch returns the latch; the narrow pin address returns pin levels.
// R15: Narrow bit 4 feeds the timer clock and narrow bit 2 external interrupt zero.
// R16: The wide latch and direction are read/write, eight bits, reset to zero; its pin address is read-only.
// R17: Each pin input passes two clk flip-flops before any reader sees it.
`default_nettype none
`include "dpdio_cfg.svh"

module dpdio_top #(
  parameter int WIDE_W   = `DPDIO_WIDE_W,
  parameter int NARROW_W = `DPDIO_NARROW_W
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // Core I/O bus
  input  wire logic [`DPDIO_ADDR_W-1:0]   ioAddr,
  input  wire logic                       ioWrEn,
  input  wire logic [`DPDIO_DATA_W-1:0]   ioWrData,
  input  wire logic                       ioBitEn,
  input  wire logic [`DPDIO_BIDX_W-1:0]   ioBitIdx,
  input  wire logic                       ioBitVal,
  input  wire logic                       ioRdEn,
  output var  logic [`DPDIO_DATA_W-1:0]   ioRdData,
  // Wide port pads
  input  wire logic [WIDE_W-1:0]          wideIn,
  output var  logic [WIDE_W-1:0]          wideOut,
  output var  logic [WIDE_W-1:0]          wideOe,
  output var  logic [WIDE_W-1:0]          widePullUp,
  // Narrow port pads
  input  wire logic [NARROW_W-1:0]        narrowIn,
  output var  logic [NARROW_W-1:0]        narrowOut,
  output var  logic [NARROW_W-1:0]        narrowOe,
  output var  logic [NARROW_W-1:0]        narrowPullUp,
  // Serial memory programming lines
  input  wire logic                       progModeEn,
  input  wire logic                       serialDataOut,
  output var  logic                       serialClkIn,
  output var  logic                       serialDataIn,
  // Other alternate-function consumers
  output var  logic                       compInputsReady,
  output var  logic                       timerClkIn,
  output var  logic                       extIrq0In
);

  ////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Address decode, shared by the write and read paths
  function automatic dpdio_pkg::dpdio_sel_t selDecode(
    input logic [`DPDIO_ADDR_W-1:0] a
  );
    dpdio_pkg::dpdio_sel_t s;
    s = dpdio_pkg::SEL_NONE;
    case (a)
      `DPDIO_ADDR_NPIN: s = dpdio_pkg::SEL_NPIN;
      `DPDIO_ADDR_NDIR: s = dpdio_pkg::SEL_NDIR;
      `DPDIO_ADDR_NLAT: s = dpdio_pkg::SEL_NLAT;
      `DPDIO_ADDR_WPIN: s = dpdio_pkg::SEL_WPIN;
      `DPDIO_ADDR_WDIR: s = dpdio_pkg::SEL_WDIR;
      `DPDIO_ADDR_WLAT: s = dpdio_pkg::SEL_WLAT;
      default:          s = dpdio_pkg::SEL_NONE;
    endcase
    return s;
  endfunction

  // Single-bit update that leaves every other bit untouched
  function automatic logic [`DPDIO_DATA_W-1:0] bitMerge(
    input logic [`DPDIO_DATA_W-1:0] cur,
    input logic [`DPDIO_BIDX_W-1:0] idx,
    input logic                     val
  );
    logic [`DPDIO_DATA_W-1:0] r;
    r      = cur;
    r[idx] = val;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  dpdio_pkg::dpdio_sel_t      wrSel;
  dpdio_pkg::dpdio_sel_t      rdSel;

  logic [WIDE_W-1:0]          wideDir_reg;
  logic [WIDE_W-1:0]          wideDir_next;
  logic [WIDE_W-1:0]          wideLat_reg;
  logic [WIDE_W-1:0]          wideLat_next;
  logic [NARROW_W-1:0]        narrowDir_reg;
  logic [NARROW_W-1:0]        narrowDir_next;
  logic [NARROW_W-1:0]        narrowLat_reg;
  logic [NARROW_W-1:0]        narrowLat_next;

  logic [WIDE_W-1:0]          wideSync;
  logic [NARROW_W-1:0]        narrowSync;

  logic [`DPDIO_DATA_W-1:0]   wideDirPad;
  logic [`DPDIO_DATA_W-1:0]   wideLatPad;
  logic [`DPDIO_DATA_W-1:0]   wideSyncPad;
  logic [`DPDIO_DATA_W-1:0]   narrowDirPad;
  logic [`DPDIO_DATA_W-1:0]   narrowLatPad;
  logic [`DPDIO_DATA_W-1:0]   narrowSyncPad;
  logic [`DPDIO_DATA_W-1:0]   wideDirBit;
  logic [`DPDIO_DATA_W-1:0]   wideLatBit;
  logic [`DPDIO_DATA_W-1:0]   narrowDirBit;
  logic [`DPDIO_DATA_W-1:0]   narrowLatBit;
  logic [`DPDIO_DATA_W-1:0]   rdData_next;

  logic [WIDE_W-1:0]          wideOeEff;
  logic [WIDE_W-1:0]          wideDrvEff;
  logic [WIDE_W-1:0]          widePuEff;
  logic [WIDE_W-1:0]          wideOeHold_reg;
  logic [WIDE_W-1:0]          widePuHold_reg;
  logic [NARROW_W-1:0]        narrowOeHold_reg;
  logic [NARROW_W-1:0]        narrowPuHold_reg;

  logic                       wideDirWr;
  logic                       wideLatWr;
  logic                       narrowDirWr;
  logic                       narrowLatWr;
  logic                       wideDirBitWr;
  logic                       wideLatBitWr;
  logic                       narrowDirBitWr;
  logic                       narrowLatBitWr;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Every pin level is two flops old before anything reads it
  dpdio_sync #(
    .W    (WIDE_W)
  ) u_wideSync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (wideIn),
    .dout    (wideSync)
  ); // [R08] [R17]

  dpdio_sync #(
    .W    (NARROW_W)
  ) u_narrowSync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (narrowIn),
    .dout    (narrowSync)
  ); // [R08] [R17]

  ////////////////////////////////////////////////////////////////////////
  // Address decode and write strobes

  // Pin-level addresses are read-only, so they get no strobe at all
  assign wrSel          = selDecode(ioAddr);
  assign rdSel          = selDecode(ioAddr);
  assign wideDirWr      = ioWrEn && (wrSel == dpdio_pkg::SEL_WDIR);
  assign wideLatWr      = ioWrEn && (wrSel == dpdio_pkg::SEL_WLAT);
  assign narrowDirWr    = ioWrEn && (wrSel == dpdio_pkg::SEL_NDIR);
  assign narrowLatWr    = ioWrEn && (wrSel == dpdio_pkg::SEL_NLAT);
  assign wideDirBitWr   = ioBitEn && (wrSel == dpdio_pkg::SEL_WDIR);
  assign wideLatBitWr   = ioBitEn && (wrSel == dpdio_pkg::SEL_WLAT);
  assign narrowDirBitWr = ioBitEn && (wrSel == dpdio_pkg::SEL_NDIR);
  assign narrowLatBitWr = ioBitEn && (wrSel == dpdio_pkg::SEL_NLAT);

  ////////////////////////////////////////////////////////////////////////
  // Zero-extended views of the registers on the 8-bit data path

  // Narrow bit 7 has no storage behind it and always reads zero
  assign wideDirPad    = `DPDIO_DATA_W'(wideDir_reg);
  assign wideLatPad    = `DPDIO_DATA_W'(wideLat_reg);
  assign wideSyncPad   = `DPDIO_DATA_W'(wideSync);
  assign narrowDirPad  = `DPDIO_DATA_W'(narrowDir_reg); // [R10]
  assign narrowLatPad  = `DPDIO_DATA_W'(narrowLat_reg); // [R10]
  assign narrowSyncPad = `DPDIO_DATA_W'(narrowSync);    // [R10]

  // Bit set/clear lets software change one pin without touching others
  assign wideDirBit   = bitMerge(wideDirPad, ioBitIdx, ioBitVal);
  assign wideLatBit   = bitMerge(wideLatPad, ioBitIdx, ioBitVal);
  assign narrowDirBit = bitMerge(narrowDirPad, ioBitIdx, ioBitVal);
  assign narrowLatBit = bitMerge(narrowLatPad, ioBitIdx, ioBitVal);

  ////////////////////////////////////////////////////////////////////////
  // Next values of the control registers

  // A full byte write wins over a bit update in the same cycle
  // Narrow casts drop bit 7, so writes to that bit are lost on purpose
  assign wideDir_next =
    wideDirWr    ? WIDE_W'(ioWrData) :
    wideDirBitWr ? WIDE_W'(wideDirBit) :
                   wideDir_reg; // [R16]
  assign wideLat_next =
    wideLatWr    ? WIDE_W'(ioWrData) :
    wideLatBitWr ? WIDE_W'(wideLatBit) :
                   wideLat_reg; // [R16]
  assign narrowDir_next =
    narrowDirWr    ? NARROW_W'(ioWrData) :
    narrowDirBitWr ? NARROW_W'(narrowDirBit) :
                     narrowDir_reg; // [R09] [R10]
  assign narrowLat_next =
    narrowLatWr    ? NARROW_W'(ioWrData) :
    narrowLatBitWr ? NARROW_W'(narrowLatBit) :
                     narrowLat_reg; // [R09] [R10]

  // Direction and latch storage, zero after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wideDir_reg   <= WIDE_W'(`DPDIO_DIR_RST);   // [R16]
      wideLat_reg   <= WIDE_W'(`DPDIO_LAT_RST);   // [R16]
      narrowDir_reg <= NARROW_W'(`DPDIO_DIR_RST); // [R10]
      narrowLat_reg <= NARROW_W'(`DPDIO_LAT_RST); // [R10]
    end else begin
      wideDir_reg   <= wideDir_next;
      wideLat_reg   <= wideLat_next;
      narrowDir_reg <= narrowDir_next;
      narrowLat_reg <= narrowLat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  // Latch addresses return storage, pin addresses return pin levels
  always_comb begin
    case (rdSel)
      dpdio_pkg::SEL_WPIN: rdData_next = wideSyncPad;   // [R04]
      dpdio_pkg::SEL_WDIR: rdData_next = wideDirPad;
      dpdio_pkg::SEL_WLAT: rdData_next = wideLatPad;    // [R04]
      dpdio_pkg::SEL_NPIN: rdData_next = narrowSyncPad; // [R14]
      dpdio_pkg::SEL_NDIR: rdData_next = narrowDirPad;
      dpdio_pkg::SEL_NLAT: rdData_next = narrowLatPad;  // [R14]
      default:             rdData_next = `DPDIO_RD_IDLE;
    endcase
  end

  // Read data is registered; it holds until the next read strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ioRdData <= `DPDIO_RD_IDLE;
    end else if (ioRdEn) begin
      ioRdData <= rdData_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wide port pin control

  // Identical per-pin logic; the serial lines override three pins
  generate
    for (genvar i = 0; i < WIDE_W; i++) begin : g_wide
      if (i == `DPDIO_BIT_SDO) begin : g_sdo
        // Programming mode drives serial data out on this pin
        assign wideOeEff[i]  = progModeEn | wideDir_reg[i];  // [R06]
        assign wideDrvEff[i] = progModeEn ? serialDataOut
                                          : wideLat_reg[i];  // [R06]
        assign widePuEff[i]  = ~progModeEn & ~wideDir_reg[i]
                               & wideLat_reg[i];             // [R02]
      end else if ((i == `DPDIO_BIT_SCK) || (i == `DPDIO_BIT_SDI)) begin
        : g_sin
        // Serial clock and data in: forced to plain inputs while progModeEn is set
        assign wideOeEff[i]  = ~progModeEn & wideDir_reg[i]; // [R06]
        assign wideDrvEff[i] = wideLat_reg[i];
        assign widePuEff[i]  = ~progModeEn & ~wideDir_reg[i]
                               & wideLat_reg[i];             // [R02]
      end else begin : g_gpio
        assign wideOeEff[i]  = wideDir_reg[i];               // [R01] [R05]
        assign wideDrvEff[i] = wideLat_reg[i];               // [R01] [R05]
        assign widePuEff[i]  = ~wideDir_reg[i]
                               & wideLat_reg[i];             // [R02] [R05]
      end
    end
  endgenerate

  // Drive value and enable are re-timed so they change together
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wideOut        <= {WIDE_W{1'b0}};
      wideOeHold_reg <= {WIDE_W{1'b0}};
      widePuHold_reg <= {WIDE_W{1'b0}};
    end else begin
      wideOut        <= wideDrvEff;
      wideOeHold_reg <= wideOeEff;
      widePuHold_reg <= widePuEff;
    end
  end

  // Reset gates the enables directly, so pins float with no clock
  assign wideOe     = wideOeHold_reg & {WIDE_W{~sys_rst}}; // [R03]
  assign widePullUp = widePuHold_reg & {WIDE_W{~sys_rst}}; // [R02] [R03]

  ////////////////////////////////////////////////////////////////////////
  // Narrow port pin control

  // Push-pull output when the direction bit is set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      narrowOut        <= {NARROW_W{1'b0}};
      narrowOeHold_reg <= {NARROW_W{1'b0}};
      narrowPuHold_reg <= {NARROW_W{1'b0}};
    end else begin
      narrowOut        <= narrowLat_reg;                  // [R11]
      narrowOeHold_reg <= narrowDir_reg;                  // [R11]
      narrowPuHold_reg <= ~narrowDir_reg & narrowLat_reg; // [R12]
    end
  end

  // Same asynchronous float as the wide port
  assign narrowOe     = narrowOeHold_reg & {NARROW_W{~sys_rst}}; // [R13]
  assign narrowPullUp = narrowPuHold_reg & {NARROW_W{~sys_rst}}; // [R13]

  ////////////////////////////////////////////////////////////////////////
  // Alternate-function consumers

  // All of these see only synchronised pin levels
  assign serialClkIn  = wideSync[`DPDIO_BIT_SCK];    // [R06] [R08]
  assign serialDataIn = wideSync[`DPDIO_BIT_SDI];    // [R06] [R08]
  assign timerClkIn   = narrowSync[`DPDIO_BIT_TCLK]; // [R15]
  assign extIrq0In    = narrowSync[`DPDIO_BIT_IRQ0]; // [R15]

  // Comparator pins are usable only as inputs with pull-ups off;
  // software must set this up, the flag only reports it
  assign compInputsReady =
    ~wideDir_reg[`DPDIO_BIT_CPOS] & ~wideLat_reg[`DPDIO_BIT_CPOS] &
    ~wideDir_reg[`DPDIO_BIT_CNEG] & ~wideLat_reg[`DPDIO_BIT_CNEG]; // [R07]

endmodule

`default_nettype wire

//--- testbench/dpdio_top_sva.sv
// Checker for the dual digital I/O port, watching only the top's ports.
// Assumes a bind from the bench and the shared config header.
`default_nettype none
`include "dpdio_cfg.svh"

module dpdio_top_sva #(
  parameter int WIDE_W   = 8,
  parameter int NARROW_W = 7
) (
  input wire logic                     clk,
  input wire logic                     sys_rst,
  input wire logic [`DPDIO_ADDR_W-1:0] ioAddr,
  input wire logic                     ioWrEn,
  input wire logic [`DPDIO_DATA_W-1:0] ioWrData,
  input wire logic                     ioBitEn,
  input wire logic                     ioRdEn,
  input wire logic [`DPDIO_DATA_W-1:0] ioRdData,
  input wire logic [WIDE_W-1:0]        wideIn,
  input wire logic [WIDE_W-1:0]        wideOut,
  input wire logic [WIDE_W-1:0]        wideOe,
  input wire logic [WIDE_W-1:0]        widePullUp,
  input wire logic [NARROW_W-1:0]      narrowIn,
  input wire logic [NARROW_W-1:0]      narrowOe,
  input wire logic [NARROW_W-1:0]      narrowPullUp,
  input wire logic                     serialClkIn,
  input wire logic                     timerClkIn,
  input wire logic                     extIrq0In
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic mapped;

  ////////////////////////////////////////////////////////////////////////
  // Decoded map, so unmapped reads can be told apart
  assign mapped = ioAddr inside {`DPDIO_ADDR_NPIN, `DPDIO_ADDR_NDIR,
    `DPDIO_ADDR_NLAT, `DPDIO_ADDR_WPIN, `DPDIO_ADDR_WDIR, `DPDIO_ADDR_WLAT};

  ////////////////////////////////////////////////////////////////////////
  // Reset floats pads with no clock edge needed, so no disable here
  wide_float_a: assert property (
    disable iff (1'b0) sys_rst |-> (wideOe | widePullUp) == '0)
    else $error("Wide pins not floating in reset");
  narrow_float_a: assert property (
    disable iff (1'b0) sys_rst |-> (narrowOe | narrowPullUp) == '0)
    else $error("Narrow pins not floating in reset");
  pull_excl_a: assert property (
    (widePullUp & wideOe) == '0 && (narrowPullUp & narrowOe) == '0)
    else $error("Pull-up on while pin drives");
  // Bits 7 to 5 are left out: programming mode may override them
  wide_dir_a: assert property (
    ioWrEn && ioAddr == `DPDIO_ADDR_WDIR ##1 !ioWrEn && !ioBitEn
    |-> ##1 wideOe[4:0] == $past(ioWrData[4:0], 2))
    else $error("Wide enable does not follow direction write");
  wide_out_a: assert property (
    ioWrEn && ioAddr == `DPDIO_ADDR_WLAT ##1 !ioWrEn && !ioBitEn
    |-> ##1 wideOut[4:0] == $past(ioWrData[4:0], 2))
    else $error("Wide drive does not follow latch write");
  narrow_dir_a: assert property (
    ioWrEn && ioAddr == `DPDIO_ADDR_NDIR ##1 !ioWrEn && !ioBitEn
    |-> ##1 narrowOe == $past(ioWrData[NARROW_W-1:0], 2))
    else $error("Narrow enable does not follow direction write");
  latch_read_a: assert property (
    ioWrEn && ioAddr == `DPDIO_ADDR_NLAT ##1 !ioWrEn && !ioBitEn
    ##1 ioRdEn && ioAddr == `DPDIO_ADDR_NLAT
    |=> ioRdData == {1'b0, $past(ioWrData[6:0], 3)})
    else $error("Narrow latch read differs from write");
  unmapped_read_a: assert property (
    ioRdEn && !mapped |=> ioRdData == 8'h00)
    else $error("Unmapped read not zero");
  pin_read_a: assert property (
    !$past(sys_rst) && !$past(sys_rst, 2) && ioRdEn
    && ioAddr == `DPDIO_ADDR_WPIN |=> ioRdData == $past(wideIn, 3))
    else $error("Wide pin read not two flops late");
  alt_sync_a: assert property (
    !$past(sys_rst) && !$past(sys_rst, 2) |-> {timerClkIn, extIrq0In,
    serialClkIn} == {$past(narrowIn[4], 2), $past(narrowIn[2], 2),
    $past(wideIn[7], 2)})
    else $error("Alternate input not two flops late");
endmodule

`default_nettype wire

//--- testbench/dpdio_board.sv
// Board model for one port: each pad is driven by the block, by a
// bench driver, by the pull-up, or else floats.
// Where the bench drives a pad that the block is driving, the block's value wins.
`default_nettype none

module dpdio_board #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] pinOut,
  input  wire logic [W-1:0] pinOe,
  input  wire logic [W-1:0] pinPullUp,
  input  wire logic [W-1:0] extEn,
  input  wire logic [W-1:0] extVal,
  output var  logic [W-1:0] pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // A floating pad must not look settled, so it flips every cycle
  always @(posedge clk) begin
    flip <= ~flip;
  end
  // Block drive wins, then the board driver, then the pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pinOe[i]) pinLevel[i] = pinOut[i];
      else if (extEn[i]) pinLevel[i] = extVal[i];
      else if (pinPullUp[i]) pinLevel[i] = 1'b1;
      else pinLevel[i] = flip;
    end
  end
endmodule

`default_nettype wire

//--- testbench/dual_port_digital_io_test.sv
// Bench for the dual digital I/O port: bus tasks, board models, checks.
// Assumes the config header and the checker file are compiled with it.
`default_nettype none
`include "dpdio_cfg.svh"

module dual_port_digital_io_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [5:0] ioAddr = '0;
  logic       ioWrEn = 1'b0;
  logic [7:0] ioWrData = '0;
  logic       ioBitEn = 1'b0;
  logic [2:0] ioBitIdx = '0;
  logic       ioBitVal = 1'b0;
  logic       ioRdEn = 1'b0;
  logic [7:0] ioRdData, wideIn, wideOut, wideOe, widePullUp;
  logic [6:0] narrowIn, narrowOut, narrowOe, narrowPullUp;
  logic       progModeEn = 1'b0;
  logic       serialDataOut = 1'b0;
  logic       serialClkIn, serialDataIn, compInputsReady;
  logic       timerClkIn, extIrq0In;
  logic [7:0] wExtEn = '0, wExtVal = '0, d, l;
  logic [6:0] nExtEn = '0, nExtVal = '0;
  int         mismatches = 0, samplesChecked = 0;

  ////////////////////////////////////////////////////////////////////////
  // Block and the boards on both ports
  always #5 clk = ~clk;
  dpdio_top DUT (.clk, .sys_rst, .ioAddr, .ioWrEn, .ioWrData, .ioBitEn,
    .ioBitIdx, .ioBitVal, .ioRdEn, .ioRdData, .wideIn, .wideOut, .wideOe,
    .widePullUp, .narrowIn, .narrowOut, .narrowOe, .narrowPullUp,
    .progModeEn, .serialDataOut, .serialClkIn, .serialDataIn,
    .compInputsReady, .timerClkIn, .extIrq0In);
  dpdio_board #(.W(8)) wideBoard (.clk, .pinOut(wideOut), .pinOe(wideOe),
    .pinPullUp(widePullUp), .extEn(wExtEn), .extVal(wExtVal),
    .pinLevel(wideIn));
  dpdio_board #(.W(7)) narrowBoard (.clk, .pinOut(narrowOut),
    .pinOe(narrowOe), .pinPullUp(narrowPullUp), .extEn(nExtEn),
    .extVal(nExtVal), .pinLevel(narrowIn));

  ////////////////////////////////////////////////////////////////////////
  // Bus tasks; each leaves one idle cycle so strobes never re-fire
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(negedge clk);
    ioAddr = a;
    ioWrData = v;
    ioWrEn = 1'b1;
    @(negedge clk);
    ioWrEn = 1'b0;
  endtask
  task automatic bw(input logic [5:0] a, input logic [2:0] i, input logic v);
    @(negedge clk);
    ioAddr = a;
    ioBitIdx = i;
    ioBitVal = v;
    ioBitEn = 1'b1;
    @(negedge clk);
    ioBitEn = 1'b0;
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    @(negedge clk);
    ioAddr = a;
    ioRdEn = 1'b1;
    @(negedge clk);
    ioRdEn = 1'b0;
    check(ioRdData, exp);
  endtask
  task automatic wrall(input logic [7:0] wd, input logic [7:0] wl,
                       input logic [7:0] nd, input logic [7:0] nl);
    wr(`DPDIO_ADDR_WDIR, wd);
    wr(`DPDIO_ADDR_WLAT, wl);
    wr(`DPDIO_ADDR_NDIR, nd);
    wr(`DPDIO_ADDR_NLAT, nl);
    repeat (3) @(negedge clk);
  endtask
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // A hang counts as a mismatch and still reaches the verdict
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    rdchk(`DPDIO_ADDR_WDIR, 8'h00);
    rdchk(`DPDIO_ADDR_NLAT, 8'h00);
    // Every direction/latch pairing across the pins
    for (int p = 0; p < 2; p++) begin
      d = p ? 8'hF0 : 8'h0F;
      l = p ? 8'hCC : 8'h33;
      wrall(d, l, d, l);
      check(wideOe, d);
      check(widePullUp, ~d & l);
      check(wideOut & d, l & d);
      check({1'b0, narrowOe}, d & 8'h7F);
      check({1'b0, narrowPullUp}, ~d & l & 8'h7F);
      check({1'b0, narrowOut} & d, l & d & 8'h7F);
      rdchk(`DPDIO_ADDR_WLAT, l);
      rdchk(`DPDIO_ADDR_NDIR, d & 8'h7F);
      rdchk(`DPDIO_ADDR_NLAT, l & 8'h7F);
    end
    $display("direction and latch test done");
    // Pin levels: driven by the block, by the board, by pull-ups
    wrall(8'hFF, 8'h5A, 8'h7F, 8'h25);
    rdchk(`DPDIO_ADDR_WPIN, 8'h5A);
    rdchk(`DPDIO_ADDR_NPIN, 8'h25);
    wExtEn = 8'hFF;
    wExtVal = 8'h96;
    nExtEn = 7'h7F;
    nExtVal = 7'h6B;
    wrall(8'h00, 8'h00, 8'h00, 8'h00);
    wr(`DPDIO_ADDR_WPIN, 8'hFF);
    wr(`DPDIO_ADDR_NPIN, 8'hFF);
    wr(6'h20, 8'hFF);
    rdchk(`DPDIO_ADDR_WPIN, 8'h96);
    rdchk(`DPDIO_ADDR_NPIN, 8'h6B);
    rdchk(6'h20, 8'h00);
    wExtEn = 8'h00;
    nExtEn = 7'h00;
    wrall(8'h00, 8'hFF, 8'h00, 8'hFF);
    rdchk(`DPDIO_ADDR_WPIN, 8'hFF);
    rdchk(`DPDIO_ADDR_NPIN, 8'h7F);
    $display("pin level test done");
    // Alternate inputs appear exactly two edges after the pin moves
    wrall(8'h00, 8'h00, 8'h00, 8'h00);
    wExtEn = 8'hA0;
    nExtEn = 7'h14;
    wExtVal = 8'h00;
    nExtVal = 7'h00;
    repeat (3) @(negedge clk);
    wExtVal = 8'hA0;
    nExtVal = 7'h14;
    @(negedge clk);
    check({serialClkIn, serialDataIn, timerClkIn, extIrq0In}, 8'h00);
    @(negedge clk);
    check({serialClkIn, serialDataIn, timerClkIn, extIrq0In}, 8'h0F);
    wExtEn = 8'h00;
    nExtEn = 7'h00;
    // Programming mode takes over the serial lines
    wrall(8'hFF, 8'h00, 8'h7F, 8'h7F);
    progModeEn = 1'b1;
    serialDataOut = 1'b1;
    repeat (2) @(negedge clk);
    check(wideOe & 8'hE0, 8'h40);
    check(wideOut & 8'h40, 8'h40);
    progModeEn = 1'b0;
    $display("alternate function test done");
    // Reset floats the pads before any clock edge
    sys_rst = 1'b1;
    #1;
    check(wideOe | widePullUp, 8'h00);
    check({1'b0, narrowOe | narrowPullUp}, 8'h00);
    @(negedge clk);
    sys_rst = 1'b0;
    rdchk(`DPDIO_ADDR_NDIR, 8'h00);
    check({7'h00, compInputsReady}, 8'h01);
    bw(`DPDIO_ADDR_WDIR, 3'h3, 1'b1);
    bw(`DPDIO_ADDR_NLAT, 3'h7, 1'b1);
    bw(`DPDIO_ADDR_NLAT, 3'h2, 1'b1);
    bw(`DPDIO_ADDR_WLAT, 3'h0, 1'b1);
    rdchk(`DPDIO_ADDR_WDIR, 8'h08);
    rdchk(`DPDIO_ADDR_NLAT, 8'h04);
    check({7'h00, compInputsReady}, 8'h00);
    wr(`DPDIO_ADDR_NLAT, 8'hFF);
    rdchk(`DPDIO_ADDR_NLAT, 8'h7F);
    $display("reset and bit write test done");
    wrap_up();
  end
endmodule

bind dpdio_top dpdio_top_sva #(.WIDE_W(WIDE_W), .NARROW_W(NARROW_W)) chk (
  .clk, .sys_rst, .ioAddr, .ioWrEn, .ioWrData, .ioBitEn, .ioRdEn,
  .ioRdData, .wideIn, .wideOut, .wideOe, .widePullUp, .narrowIn,
  .narrowOe, .narrowPullUp, .serialClkIn, .timerClkIn, .extIrq0In);

`default_nettype wire
